/* hw/pcp_top.sv */
`timescale 1ns/1ps
`include "pcp_map.svh"
module pcp_top #(
   parameter int ADDR_W   = 12,
   parameter int CNT_W    = 22,
   parameter int LOCK_CYC = `PCP_LOCK_MS * `PCP_CLK_KHZ,
   parameter int SUT1_CYC = (`PCP_SUT1_US * `PCP_CLK_KHZ) / 1000,
   parameter int SUT2_CYC = (`PCP_SUT2_US * `PCP_CLK_KHZ) / 1000
) (
   // Clock, reset, freeze
   input  wire logic                 core_clk,
   input  wire logic                 reset_n,
   input  wire logic                 clk_en,
   // APB slave
   input  wire logic [ADDR_W-1:0]    paddr,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Pins and fuses
   input  wire logic                 osc_input_pin,
   input  wire pcp_pkg::pcp_fuse_t   fuse_pins,
   input  wire logic                 power_down,
   // PLL and oscillators
   output logic                      pll_enable_out,
   output logic                      rc_osc_enable,
   output logic                      pll_locked_psc,
   output logic      [6:0]           pll_freq_mhz,
   output logic                      wdt_osc_enable,
   // System clocks
   output pcp_pkg::pcp_clk_en_t      clk_en_out,
   output logic                      sys_clk_div,
   output logic                      clock_out_pin,
   output logic                      clock_out_oe,
   output logic                      core_ready
);

   // ****************************************************************
   // Functions
   // ****************************************************************
   function automatic logic [ADDR_W-1:0] pcp_byte_addr(input logic [7:0] idx);
      return ADDR_W'({idx, 2'b00});
   endfunction : pcp_byte_addr

   function automatic logic [8:0] pcp_factor(input logic [3:0] code);
      return 9'h001 << code;
   endfunction : pcp_factor

   // ****************************************************************
   // Reset and input synchronisers
   // ****************************************************************
   logic                 rstMeta;
   logic                 rstSync;
   logic [8:0]           syncA;
   logic [8:0]           syncB;
   logic [8:0]           syncC;
   logic [8:0]           filt;
   logic                 oscPrev;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // A bit changes only once stages two and three agree
   wire  [8:0]           pinBus   = {osc_input_pin, fuse_pins};
   wire  [8:0]           pinAgree = ~(syncB ^ syncC);
   wire  [8:0]           next_filt = (pinAgree & syncC) | (~pinAgree & filt);

   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         syncA   <= 9'h000;
         syncB   <= 9'h000;
         syncC   <= 9'h000;
         filt    <= 9'h000;
         oscPrev <= 1'b0;
      end else if (clk_en) begin
         syncA   <= pinBus;
         syncB   <= syncA;
         syncC   <= syncB;
         filt    <= next_filt;
         oscPrev <= filt[8];
      end
   end

   wire pcp_pkg::pcp_fuse_t fuseF = pcp_pkg::pcp_fuse_t'(filt[7:0]);
   wire                 oscF     = filt[8];
   wire                 extSel   = fuseF.src == `PCP_SRC_EXT;
   wire                 pllIsSys = fuseF.src == `PCP_SRC_PLL;
   wire                 rcSel    = fuseF.src == `PCP_SRC_RC;
   // External source ticks on its rising edge; internal sources every cycle
   wire                 srcTick  = extSel ? (oscF & ~oscPrev) : 1'b1;

   // ****************************************************************
   // Fuse strap capture after reset release
   // ****************************************************************
   logic [2:0]           bootCnt;
   wire                  bootLoad = bootCnt == `PCP_BOOT_LOAD;
   wire                  bootDone = bootCnt == `PCP_BOOT_DONE;

   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         bootCnt <= 3'h0;
      end else if (clk_en && !bootDone) begin
         bootCnt <= 3'(bootCnt + 3'h1);
      end
   end

   // ****************************************************************
   // APB decode
   // ****************************************************************
   logic                 rateSel;
   logic                 pllEnBit;
   logic                 pllLocked;
   logic                 unlock;
   logic [2:0]           unlockCnt;
   logic [3:0]           presc;

   wire                  selPll     = paddr == pcp_byte_addr(`PCP_PLL_CTRL_IDX);
   wire                  selPresc   = paddr == pcp_byte_addr(`PCP_CLK_PRESC_IDX);
   wire                  accessWait = psel & penable & ~pready;
   wire                  apbDone    = psel & penable & pready;
   wire                  wrPll      = apbDone & pwrite & selPll;
   wire                  clkprWr    = apbDone & pwrite & selPresc;
   wire                  pllEnEff   = pllEnBit | pllIsSys;
   // Reserved upper bits are constant zero
   wire  [7:0]           readPll    = {5'h00, rateSel, pllEnEff, pllLocked};
   wire  [7:0]           readPresc  = {unlock, 3'h0, presc};
   wire  [31:0]          next_prdata = (pwrite || !(selPll || selPresc)) ? 32'h0 :
                                       {24'h0, selPll ? readPll : readPresc};

   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready  <= accessWait;
         pslverr <= accessWait & ~(selPll | selPresc);
         if (accessWait) begin
            prdata <= next_prdata;
         end
      end
   end

   // ****************************************************************
   // Prescaler register and unlock window
   // ****************************************************************
   wire                  unlockReq = clkprWr && pwdata[7:0] == `PCP_UNLOCK_VAL;
   wire                  selWrite  = clkprWr && !pwdata[`PCP_UNLOCK_BIT];
   wire                  unlockSet = unlockReq && !unlock;
   wire                  next_unlock = unlockSet ? 1'b1 :
                                       (unlock && (selWrite || unlockCnt == 3'h1)) ? 1'b0 :
                                       unlock;
   wire  [2:0]           next_unlockCnt = unlockSet ? `PCP_UNLOCK_CYC :
                                          next_unlock ? 3'(unlockCnt - 3'h1) : 3'h0;
   // Any code is stored; reserved codes never reach the divider
   wire  [3:0]           next_presc = bootLoad ? (fuseF.div8 ? `PCP_DIV8_CODE
                                                            : `PCP_DIV1_CODE) :
                                      (unlock && selWrite) ? pwdata[3:0] : presc;

   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         unlock    <= 1'b0;
         unlockCnt <= 3'h0;
         presc     <= `PCP_DIV1_CODE;
      end else if (clk_en) begin
         unlock    <= next_unlock;
         unlockCnt <= next_unlockCnt;
         presc     <= next_presc;
      end
   end

   // ****************************************************************
   // PLL control and lock timer
   // ****************************************************************
   logic [CNT_W-1:0]     lockCnt;
   wire                  lockHit = lockCnt == CNT_W'(LOCK_CYC - 1);
   // Reference is RC / 8 at 1 MHz, output is ref * 64, halved at low rate
   wire  [6:0]           fastMhz = rateSel ? `PCP_FAST_HI_MHZ : `PCP_FAST_LO_MHZ;

   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         rateSel        <= 1'b0;
         pllEnBit       <= 1'b0;
         pllLocked      <= 1'b0;
         lockCnt        <= '0;
         pll_enable_out <= 1'b0;
         rc_osc_enable  <= 1'b0;
         pll_locked_psc <= 1'b0;
         pll_freq_mhz   <= `PCP_FAST_LO_MHZ;
         wdt_osc_enable <= 1'b0;
      end else if (clk_en) begin
         if (wrPll) begin
            rateSel  <= pwdata[`PCP_RATE_BIT];
            pllEnBit <= pwdata[`PCP_ENABLE_BIT];
         end
         if (!pllEnEff) begin
            lockCnt   <= '0;
            pllLocked <= 1'b0;
         end else if (!lockHit) begin
            lockCnt <= CNT_W'(lockCnt + 1'b1);
         end else begin
            pllLocked <= 1'b1;
         end
         pll_enable_out <= pllEnEff;
         rc_osc_enable  <= pllEnEff | rcSel;
         pll_locked_psc <= pllLocked & pllEnEff;
         pll_freq_mhz   <= fastMhz;
         wdt_osc_enable <= 1'b1;
      end
   end

   // ****************************************************************
   // Start-up sequencer
   // ****************************************************************
   pcp_pkg::pcp_state_t  state;
   pcp_pkg::pcp_state_t  next_state;
   logic [CNT_W-1:0]     stCnt;
   logic [CNT_W-1:0]     next_stCnt;

   wire                  needDelay = fuseF.startup_time_fuses == `PCP_SUT_SHORT || fuseF.startup_time_fuses == `PCP_SUT_LONG;
   wire  [CNT_W-1:0]     delayCyc  = (fuseF.startup_time_fuses == `PCP_SUT_SHORT) ? CNT_W'(SUT1_CYC)
                                                                  : CNT_W'(SUT2_CYC);
   wire                  ckLast    = srcTick && stCnt == CNT_W'(`PCP_RST_CK - 1);
   wire                  wakeLast  = srcTick && stCnt == CNT_W'(`PCP_PD_CK - 1);
   wire  [CNT_W-1:0]     stInc     = CNT_W'(stCnt + 1'b1);

   // Reserved startup code behaves as code 00, with no delay
   always_comb begin
      next_state = state;
      next_stCnt = stCnt;
      unique case (state)
         pcp_pkg::ST_CK: begin
            if (bootDone && ckLast) begin
               next_state = needDelay ? pcp_pkg::ST_DLY : pcp_pkg::ST_RUN;
               next_stCnt = '0;
            end else if (bootDone && srcTick) begin
               next_stCnt = stInc;
            end
         end
         pcp_pkg::ST_DLY: begin
            if (stCnt == CNT_W'(delayCyc - 1'b1)) begin
               next_state = pcp_pkg::ST_RUN;
               next_stCnt = '0;
            end else begin
               next_stCnt = stInc;
            end
         end
         pcp_pkg::ST_RUN: begin
            if (power_down) begin
               next_state = pcp_pkg::ST_SLEEP;
            end
         end
         pcp_pkg::ST_SLEEP: begin
            if (!power_down) begin
               next_state = pcp_pkg::ST_WAKE;
               next_stCnt = '0;
            end
         end
         pcp_pkg::ST_WAKE: begin
            if (wakeLast) begin
               next_state = pcp_pkg::ST_RUN;
               next_stCnt = '0;
            end else if (srcTick) begin
               next_stCnt = stInc;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         state      <= pcp_pkg::ST_CK;
         stCnt      <= '0;
         core_ready <= 1'b0;
      end else if (clk_en) begin
         state      <= next_state;
         stCnt      <= next_stCnt;
         core_ready <= next_state == pcp_pkg::ST_RUN;
      end
   end

   // ****************************************************************
   // Glitch-free system clock prescaler
   // ****************************************************************
   logic [3:0]           activeSel;
   logic [7:0]           divCnt;

   wire  [8:0]           factor    = pcp_factor(activeSel);
   // New code is taken only at the end of a full old period, so no short pulse
   wire                  boundary  = srcTick && {1'b0, divCnt} == 9'(factor - 9'h001);
   wire                  prescOk   = presc <= `PCP_MAX_CODE;
   wire  [3:0]           next_activeSel = (boundary && prescOk) ? presc : activeSel;
   wire  [7:0]           next_divCnt = boundary ? 8'h00 :
                                       srcTick ? 8'(divCnt + 8'h01) : divCnt;
   wire  [8:0]           nextFactor = pcp_factor(next_activeSel);
   // External source at factor one follows the pin itself, so the pin is not halved
   wire                  next_level = (nextFactor != 9'h001) ?
                                      ({1'b0, next_divCnt} < (nextFactor >> 1)) :
                                      (extSel ? oscF : (sys_clk_div ^ srcTick));
   wire                  runClk    = next_state == pcp_pkg::ST_RUN;

   // Divider runs through the reset delay so the clock-out pin is alive
   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         activeSel     <= `PCP_DIV1_CODE;
         divCnt        <= 8'h00;
         sys_clk_div   <= 1'b0;
         clk_en_out    <= '0;
         clock_out_pin <= 1'b0;
         clock_out_oe  <= 1'b0;
      end else if (clk_en) begin
         activeSel     <= next_activeSel;
         divCnt        <= next_divCnt;
         sys_clk_div   <= next_level;
         clk_en_out    <= pcp_pkg::pcp_clk_en_t'({4{boundary & runClk}});
         clock_out_pin <= fuseF.clock_out_fuse & next_level;
         clock_out_oe  <= fuseF.clock_out_fuse;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cbDef @(posedge core_clk); endclocking
   default disable iff (!rstSync);

   logic [3:0]           unlockAge;
   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         unlockAge <= 4'h0;
      end else if (clk_en) begin
         unlockAge <= next_unlock ? 4'(unlockAge + 4'h1) : 4'h0;
      end
   end

   property p_pll_reserved;
      accessWait && !pwrite && selPll |=> prdata[31:3] == 29'h0;
   endproperty
   a_pll_reserved: assert property (p_pll_reserved) else $error("reserved bits not zero");

   property p_enable_forced;
      clk_en && pllIsSys |=> pll_enable_out;
   endproperty
   a_enable_forced: assert property (p_enable_forced) else $error("enable not forced");

   property p_lock_needs_enable;
      clk_en && !pllEnEff |=> !pll_locked_psc && lockCnt == '0;
   endproperty
   a_lock_needs_enable: assert property (p_lock_needs_enable) else $error("lock w/o enable");

   property p_rate;
      clk_en && rateSel |=> pll_freq_mhz == 7'h40;
   endproperty
   a_rate: assert property (p_rate) else $error("fast clock rate wrong");

   property p_unlock_set;
      clk_en && unlockSet |=> unlock && unlockCnt == 3'h4;
   endproperty
   a_unlock_set: assert property (p_unlock_set) else $error("unlock not set");

   property p_unlock_partial;
      clk_en && clkprWr && pwdata[7] && pwdata[6:0] != 7'h0 && !unlock |=> !unlock;
   endproperty
   a_unlock_partial: assert property (p_unlock_partial) else $error("unlock set wrongly");

   property p_unlock_window;
      unlockAge <= 4'h4;
   endproperty
   a_unlock_window: assert property (p_unlock_window) else $error("unlock window too long");

   property p_unlock_rewrite;
      clk_en && unlock && unlockReq |=> unlockCnt == 3'($past(unlockCnt) - 3'h1) &&
                                        unlock == ($past(unlockCnt) > 3'h1);
   endproperty
   a_unlock_rewrite: assert property (p_unlock_rewrite) else $error("window extended");

   property p_select_write;
      clk_en && unlock && selWrite && !bootLoad |=> presc == $past(pwdata[3:0]) && !unlock;
   endproperty
   a_select_write: assert property (p_select_write) else $error("select not written");

   property p_select_locked;
      clk_en && !unlock && !bootLoad |=> presc == $past(presc);
   endproperty
   a_select_locked: assert property (p_select_locked) else $error("locked select changed");

   property p_boot_strap;
      clk_en && bootLoad |=> presc == ($past(fuseF.div8) ? 4'h3 : 4'h0);
   endproperty
   a_boot_strap: assert property (p_boot_strap) else $error("strap load wrong");

   property p_switch_boundary;
      clk_en && !boundary |=> activeSel == $past(activeSel);
   endproperty
   a_switch_boundary: assert property (p_switch_boundary) else $error("switch mid period");

   property p_clock_out;
      clk_en && fuseF.clock_out_fuse |=> clock_out_oe && clock_out_pin == sys_clk_div;
   endproperty
   a_clock_out: assert property (p_clock_out) else $error("clock out wrong");

   property p_ck_delay;
      clk_en && state == pcp_pkg::ST_CK && bootDone && ckLast && !needDelay |=> core_ready;
   endproperty
   a_ck_delay: assert property (p_ck_delay) else $error("start-up release late");

   c_unlock_then_select: cover property (unlockSet ##[1:4] (unlock && selWrite));
   c_pll_locked: cover property ($rose(pll_locked_psc));
   c_wake: cover property (state == pcp_pkg::ST_WAKE ##1 state == pcp_pkg::ST_RUN);
   c_switch: cover property (boundary && prescOk && presc != activeSel);

endmodule : pcp_top

/* hw/pcp_map.svh */
`ifndef PCP_MAP_SVH
`define PCP_MAP_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define PCP_PLL_CTRL_IDX   8'h29
`define PCP_CLK_PRESC_IDX  8'h2A

// ****************************************************************
// Field positions and values
// ****************************************************************
`define PCP_RATE_BIT       2
`define PCP_ENABLE_BIT     1
`define PCP_LOCK_BIT       0
`define PCP_UNLOCK_BIT     7
`define PCP_UNLOCK_VAL     8'h80
`define PCP_PLL_RESET      8'h00
`define PCP_DIV1_CODE      4'h0
`define PCP_DIV8_CODE      4'h3
`define PCP_MAX_CODE       4'h8
`define PCP_SRC_EXT        4'h0
`define PCP_SRC_RC         4'h2
`define PCP_SRC_PLL        4'h3
`define PCP_SUT_SHORT      2'h1
`define PCP_SUT_LONG       2'h2
`define PCP_FAST_HI_MHZ    7'h40
`define PCP_FAST_LO_MHZ    7'h20
`define PCP_REF_MHZ        1
`define PCP_PLL_MULT       64
`define PCP_WDT_KHZ        128

// ****************************************************************
// Timing
// ****************************************************************
`define PCP_CLK_KHZ        20000
`define PCP_LOCK_MS        100
`define PCP_SUT1_US        4100
`define PCP_SUT2_US        65000
`define PCP_RST_CK         14
`define PCP_PD_CK          6
`define PCP_UNLOCK_CYC     3'h4
`define PCP_BOOT_LOAD      3'h4
`define PCP_BOOT_DONE      3'h5

`endif

/* hw/pcp_pkg.sv */
package pcp_pkg;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic [3:0] src;
      logic [1:0] startup_time_fuses;
      logic       clock_out_fuse;
      logic       div8;
   } pcp_fuse_t;

   typedef struct packed {
      logic io;
      logic adc;
      logic cpu;
      logic flash;
   } pcp_clk_en_t;

   typedef enum logic [4:0] {
      ST_CK    = 5'b00001,
      ST_DLY   = 5'b00010,
      ST_RUN   = 5'b00100,
      ST_SLEEP = 5'b01000,
      ST_WAKE  = 5'b10000
   } pcp_state_t;

endpackage : pcp_pkg

/* bench/pcp_ext_clk.sv */
`timescale 1ns/1ps
// ****************************************************************
// External clock source on the oscillator pin
// ****************************************************************
module pcp_ext_clk #(
   parameter int HALF_NS = 100,
   parameter int OFFS_NS = 13
) (
   output logic clk
);
   // Fixed period, so no cycle-to-cycle frequency step at all
   initial begin
      clk = 1'b0;
      #(OFFS_NS);
      forever #(HALF_NS) clk = ~clk;
   end
endmodule : pcp_ext_clk

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
   // ****************************************************************
   // Stimulus and checks
   // ****************************************************************
   logic                 core_clk = 1'b0;
   logic                 reset_n = 1'b0;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic                 osc;
   logic [11:0]          paddr = 12'h000;
   logic [31:0]          pwdata = 32'h0;
   logic [31:0]          prdata;
   logic [31:0]          rd;
   logic                 pready, pslverr, err, pll_en, rc_en, lk_psc, wdt_en, sdiv, cko, coe, rdy;
   logic [6:0]           fmhz;
   pcp_pkg::pcp_clk_en_t cen;
   int                   errors = 0;
   int                   cmp_count = 0;
   int                   cyc = 0;
   time                  t0;
   // Ext source, sut 01, clock out and divide-by-8 fuses programmed
   pcp_pkg::pcp_fuse_t   fuse = 8'h07;
   always #25 core_clk = ~core_clk;
   pcp_ext_clk u_src (.clk(osc));
   pcp_top #(.LOCK_CYC(20), .SUT1_CYC(10), .SUT2_CYC(15)) dut (.core_clk(core_clk),
      .reset_n(reset_n), .clk_en(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .osc_input_pin(osc), .fuse_pins(fuse), .power_down(1'b0), .pll_enable_out(pll_en),
      .rc_osc_enable(rc_en), .pll_locked_psc(lk_psc), .pll_freq_mhz(fmhz),
      .wdt_osc_enable(wdt_en), .clk_en_out(cen), .sys_clk_div(sdiv), .clock_out_pin(cko),
      .clock_out_oe(coe), .core_ready(rdy));
   task automatic conclude;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic wp;
      do @(posedge core_clk); while (cen.cpu !== 1'b1);
   endtask : wp
   // Next rising edge of the clock-out pin
   task automatic wr;
      @(posedge core_clk);
      while (cko !== 1'b0) @(posedge core_clk);
      while (cko !== 1'b1) @(posedge core_clk);
   endtask : wr
   // Both writes back to back, nothing in between
   task automatic setdiv(input logic [7:0] c);
      apb(1'b1, 12'hA8, 32'h80);
      apb(1'b1, 12'hA8, {24'h0, c});
   endtask : setdiv
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errors++;
         conclude;
      end
   end
   initial begin
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      apb(1'b0, 12'hA4, 0); chk(rd, 32'h0);
      chk(32'({err, pll_en, rc_en, fmhz}), 32'h020);
      apb(1'b0, 12'hA8, 0); chk(rd, 32'h03);
      apb(1'b1, 12'hA4, 32'hFF); apb(1'b0, 12'hA4, 0); chk(rd, 32'h06);
      chk(32'({pll_en, rc_en, fmhz}), 32'h1C0);
      repeat (30) @(posedge core_clk);
      apb(1'b0, 12'hA4, 0); chk(rd, 32'h07); chk(32'(lk_psc), 32'h1);
      apb(1'b0, 12'h010, 0); chk(rd, 32'h0); chk(32'(err), 32'h1);
      while (rdy !== 1'b1 && cyc < 2000) @(posedge core_clk);
      chk(32'({rdy, wdt_en, coe, cko}), 32'({3'b111, sdiv}));
      for (int i = 0; i < 10; i++) begin
         setdiv(8'(i));
         apb(1'b0, 12'hA8, 0); chk(rd, 32'(i));
         wp(); wp(); wp();
         t0 = $time;
         wp();
         chk(32'(($time - t0) / 50), 4 << (i > 8 ? 8 : i));
         chk(32'(cen), 32'h0F);
         wr();
         t0 = $time;
         wr();
         chk(32'(($time - t0) / 50), 4 << (i > 8 ? 8 : i));
      end
      apb(1'b1, 12'hA8, 32'h81); apb(1'b1, 12'hA8, 32'h01);
      apb(1'b0, 12'hA8, 0); chk(rd, 32'h09);
      apb(1'b1, 12'hA8, 32'h80);
      repeat (6) @(posedge core_clk);
      apb(1'b0, 12'hA8, 0); chk(rd, 32'h09);
      apb(1'b1, 12'hA8, 32'h02); apb(1'b0, 12'hA8, 0); chk(rd, 32'h09);
      apb(1'b1, 12'hA8, 32'h80); apb(1'b0, 12'hA8, 0); chk(rd, 32'h89);
      apb(1'b1, 12'hA8, 32'h80); apb(1'b1, 12'hA8, 32'h80);
      apb(1'b1, 12'hA8, 32'h05); apb(1'b0, 12'hA8, 0); chk(rd, 32'h09);
      // Second reset: sut 00, clock out only, divide-by-8 unprogrammed
      reset_n <= 1'b0;
      fuse    <= 8'h02;
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      apb(1'b0, 12'hA4, 0); chk(rd, 32'h0);
      apb(1'b0, 12'hA8, 0); chk(rd, 32'h0);
      for (int k = 0; k < 200 && rdy !== 1'b1; k++) @(posedge core_clk);
      chk(32'({rdy, coe}), 32'h3);
      conclude;
   end
endmodule : testbench
